// ### rtl/trace_cmp_defs.svh
// Offsets, field positions, reset values and codes of the trace comparator block
`ifndef TRACE_CMP_DEFS_SVH
`define TRACE_CMP_DEFS_SVH

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define TCA_VAL_BASE   12'h400
`define TCA_VAL_LAST   12'h43c
`define TCA_QUAL_BASE  12'h480
`define TCA_QUAL_LAST  12'h4bc
`define TCA_AUTH_OFS   12'hfb8
`define TCA_AUTH_HI    12'hfbc
`define TCA_AUX_OFS    12'h018

// ************************************************************
// Qualifier fields
// ************************************************************
`define TCA_NS_EL0_BIT 12
`define TCA_S_EL0_BIT  8
`define TCA_S_EL1_BIT  9
`define TCA_S_EL3_BIT  11
`define TCA_CTX_MSB    3
`define TCA_CTX_LSB    2
`define TCA_CTX_NONE   2'h0
`define TCA_CTX_CID    2'h1
`define TCA_CTX_VIRTUAL_MACHINE_IDENTIFIER   2'h2
`define TCA_CTX_BOTH   2'h3
`define TCA_QUAL_WMASK 16'h7b0c

// ************************************************************
// Auxiliary control bits
// ************************************************************
`define TCA_AUX_FLUSH_RDY 0
`define TCA_AUX_IDLE_ACK  1
`define TCA_AUX_FRC_OVF   2
`define TCA_AUX_SYNC_ALW  3
`define TCA_AUX_TS_ALW    4
`define TCA_AUX_AUTH_FL   5
`define TCA_AUX_OVF_ALW   6
`define TCA_AUX_CLK_RUN   7
`define TCA_AUX_DBG_FL    8

// ************************************************************
// Status codes and reset values
// ************************************************************
`define TCA_STAT_OFF   2'h2
`define TCA_STAT_ON    2'h3
`define TCA_STAT_NONE  2'h0
`define TCA_VAL_RST    64'h0000000000000000
`define TCA_QUAL_RST   16'h0000
`define TCA_AUX_RST    9'h000

`endif

// ### rtl/trace_cmp_pkg.sv
// Types shared by the trace comparator block
`default_nettype none
package trace_cmp_pkg;
  // Full comparator address
  typedef logic [63:0] cmp_addr_t;
  // Stored low half of a qualifier
  typedef logic [15:0] qual_t;
  // Auxiliary override bits
  typedef logic [8:0]  aux_t;
  // Three-stage pin synchroniser
  typedef logic [2:0]  sync_t;
endpackage
`default_nettype wire

// ### rtl/trace_comparator_aux_control.sv
// Trace comparator qualification, permission status and auxiliary overrides
`timescale 1ns/1ps
`default_nettype none
`include "trace_cmp_defs.svh"

module trace_comparator_aux_control #(
  parameter int NUM_CMP = 8
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  // Debug register port
  input  wire logic        dbg_sel,
  input  wire logic        dbg_write,
  input  wire logic [11:0] dbg_addr,
  input  wire logic [31:0] dbg_wdata,
  output var  logic [31:0] dbg_rdata,
  output var  logic        dbg_ack,
  // Enable pins from outside
  input  wire logic        noninvasive_debug_enable,
  input  wire logic        invasive_debug_enable,
  input  wire logic        secure_noninv_enable,
  // Core address stream
  input  wire logic        cmp_valid,
  input  wire logic [63:0] cmp_addr,
  input  wire logic        cmp_secure,
  input  wire logic [1:0]  cmp_level,
  input  wire logic        ctxid_match,
  input  wire logic        virtual_machine_identifier_match,
  output var  logic [7:0]  addr_match,
  // Trace unit status in
  input  wire logic        debug_state_entry,
  input  wire logic        trace_idle,
  input  wire logic        fifo_drained,
  input  wire logic        trace_activity_low,
  input  wire logic        ts_request,
  input  wire logic        sync_request,
  input  wire logic        sync_delayed,
  // Trace unit controls out
  output var  logic        trace_flush_req,
  output var  logic        trace_idle_req,
  output var  logic        core_if_clock_run,
  output var  logic        core_if_overflow_ok,
  output var  logic        ts_insert,
  output var  logic        sync_insert,
  output var  logic        fifo_force_overflow,
  output var  logic        idle_ack,
  output var  logic        flush_ready
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // The address window only has room for eight comparators
  if (NUM_CMP < 1 || NUM_CMP > 8) begin : g_bad_num
    $error("NUM_CMP must be 1 to 8");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    trace_cmp_pkg::cmp_addr_t [7:0] val;   // Compare addresses
    trace_cmp_pkg::qual_t [7:0]     qual;  // Qualifier low halves
    trace_cmp_pkg::aux_t            aux;   // Override bits
    trace_cmp_pkg::sync_t [2:0]     sync;  // Pin synchronisers
    logic [2:0]                     pin;   // Filtered pin levels
    logic                           low;   // Permission low, last cycle
    logic [31:0]                    rdata; // Read answer
    logic                           ack;   // Access answered
    logic [7:0]                     match; // Qualified matches
    logic                           flush; // Flush request
    logic                           idle;  // Idle request
    logic                           clk_run;
    logic                           ovf_ok;
    logic                           ts;
    logic                           sy;
    logic                           fovf;
    logic                           iack;
    logic                           frdy;
  } state_s;

  state_s st_ff;   // Registered state
  state_s nxt_st;  // Next state

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // Word address inside an inclusive window
  function automatic logic in_win(input logic [11:0] a,
                                  input logic [11:0] lo,
                                  input logic [11:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  // Comparator index lies below the built count
  function automatic logic cmp_exists(input logic [2:0] idx);
    cmp_exists = (int'(idx) < NUM_CMP);
  endfunction

  // Security state and level filter
  function automatic logic level_ok(input trace_cmp_pkg::qual_t q,
                                    input logic sec,
                                    input logic [1:0] el);
    logic ok;
    ok = 1'b0;
    if (sec) begin
      // Secure EL2 has no control bit, so never compares
      // Secure level gate
      case (el)
        2'h0:    ok = ~q[`TCA_S_EL0_BIT];
        2'h1:    ok = ~q[`TCA_S_EL1_BIT];
        2'h3:    ok = ~q[`TCA_S_EL3_BIT];
        default: ok = 1'b0;
      endcase
    end else begin
      // Non-secure EL3 does not exist, so never compares
      // Non-secure level gate
      case (el)
        2'h0:    ok = ~q[`TCA_NS_EL0_BIT];
        2'h1:    ok = ~q[`TCA_NS_EL0_BIT + 1];
        2'h2:    ok = ~q[`TCA_NS_EL0_BIT + 2];
        default: ok = 1'b0;
      endcase
    end
    level_ok = ok;
  endfunction

  // Context qualification of an address hit
  function automatic logic ctx_ok(input trace_cmp_pkg::qual_t q,
                                  input logic cid,
                                  input logic vm);
    logic ok;
    ok = 1'b0;
    case (q[`TCA_CTX_MSB:`TCA_CTX_LSB])
      `TCA_CTX_NONE: ok = 1'b1;
      `TCA_CTX_CID:  ok = cid;
      `TCA_CTX_VIRTUAL_MACHINE_IDENTIFIER: ok = vm;
      `TCA_CTX_BOTH: ok = cid & vm;
      default:       ok = 1'b0;
    endcase
    ctx_ok = ok;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  // Decode fields of the current access
  logic [2:0] acc_idx;  // Comparator index
  logic       acc_hi;   // Upper word of a 64-bit register
  logic       perm_low; // Either enable pin low
  logic [2:0] pins_in;  // Raw pin levels

  assign acc_idx = dbg_addr[5:3];
  assign acc_hi  = dbg_addr[2];
  assign pins_in = {secure_noninv_enable, invasive_debug_enable,
                    noninvasive_debug_enable};

  // All state advances from one combinational copy
  always_comb begin
    nxt_st = st_ff;

    // Pins: the first stage only feeds the second
    for (int p = 0; p < 3; p++) begin
      nxt_st.sync[p] = {st_ff.sync[p][1:0], pins_in[p]};
      // Accept a level once the last two stages agree
      if (st_ff.sync[p][1] == st_ff.sync[p][2]) begin
        nxt_st.pin[p] = st_ff.sync[p][2];
      end
    end

    // Register writes
    nxt_st.ack = dbg_sel;
    if (dbg_sel && dbg_write) begin
      if (in_win(dbg_addr, `TCA_VAL_BASE, `TCA_VAL_LAST) && cmp_exists(acc_idx)) begin
        if (acc_hi) begin
          nxt_st.val[acc_idx][63:32] = dbg_wdata;
        end else begin
          nxt_st.val[acc_idx][31:0] = dbg_wdata;
        end
      end else if (in_win(dbg_addr, `TCA_QUAL_BASE, `TCA_QUAL_LAST)
                   && cmp_exists(acc_idx) && !acc_hi) begin
        nxt_st.qual[acc_idx] = dbg_wdata[15:0] & `TCA_QUAL_WMASK;
      end else if (dbg_addr == `TCA_AUX_OFS) begin
        nxt_st.aux = dbg_wdata[8:0];
      end
      // Other writes, including read-only status, are ignored
    end

    // Register reads; unmapped words read zero
    nxt_st.rdata = 32'h0000_0000;
    if (dbg_sel && !dbg_write) begin
      if (in_win(dbg_addr, `TCA_VAL_BASE, `TCA_VAL_LAST) && cmp_exists(acc_idx)) begin
        nxt_st.rdata = acc_hi ? st_ff.val[acc_idx][63:32] : st_ff.val[acc_idx][31:0];
      end else if (in_win(dbg_addr, `TCA_QUAL_BASE, `TCA_QUAL_LAST)
                   && cmp_exists(acc_idx) && !acc_hi) begin
        nxt_st.rdata = {16'h0000, st_ff.qual[acc_idx]};
      end else if (dbg_addr == `TCA_AUTH_OFS) begin
        nxt_st.rdata[7:6] = (st_ff.pin[2] && st_ff.pin[0]) ? `TCA_STAT_ON : `TCA_STAT_OFF;
        nxt_st.rdata[5:4] = `TCA_STAT_NONE;
        nxt_st.rdata[3:2] = st_ff.pin[0] ? `TCA_STAT_ON : `TCA_STAT_OFF;
        nxt_st.rdata[1:0] = `TCA_STAT_NONE;
      end else if (dbg_addr == `TCA_AUX_OFS) begin
        nxt_st.rdata = {23'h000000, st_ff.aux};
      end
    end

    // Address comparators, one per slot
    for (int i = 0; i < 8; i++) begin
      nxt_st.match[i] = (i < NUM_CMP) && cmp_valid
                        && (cmp_addr == st_ff.val[i])
                        && level_ok(st_ff.qual[i], cmp_secure, cmp_level)
                        && ctx_ok(st_ff.qual[i], ctxid_match,
                                  virtual_machine_identifier_match);
    end

    // Permission drop: flush once on the fall, hold idle while low
    nxt_st.low = perm_low;
    nxt_st.flush = (debug_state_entry && !st_ff.aux[`TCA_AUX_DBG_FL])
                   || (perm_low && !st_ff.low && !st_ff.aux[`TCA_AUX_AUTH_FL]);
    nxt_st.idle = perm_low && !st_ff.aux[`TCA_AUX_AUTH_FL];

    nxt_st.clk_run = st_ff.aux[`TCA_AUX_CLK_RUN];
    nxt_st.ovf_ok = st_ff.aux[`TCA_AUX_OVF_ALW];
    nxt_st.ts = ts_request && (trace_activity_low || st_ff.aux[`TCA_AUX_TS_ALW]);
    nxt_st.sy = sync_request && (trace_activity_low || st_ff.aux[`TCA_AUX_SYNC_ALW]);
    nxt_st.fovf = sync_delayed && st_ff.aux[`TCA_AUX_FRC_OVF];
    nxt_st.iack = trace_idle || st_ff.aux[`TCA_AUX_IDLE_ACK];
    nxt_st.frdy = trace_idle || fifo_drained || st_ff.aux[`TCA_AUX_FLUSH_RDY];

    // Synchronous reset to defined values
    if (rst) begin
      nxt_st.val   = {8{`TCA_VAL_RST}};
      nxt_st.qual  = {8{`TCA_QUAL_RST}};
      nxt_st.aux   = `TCA_AUX_RST;
      nxt_st.sync  = '0;
      nxt_st.pin   = 3'h0;
      nxt_st.low   = 1'b1;
      nxt_st.rdata = 32'h0000_0000;
      nxt_st.ack   = 1'b0;
      nxt_st.match = 8'h00;
      nxt_st.flush = 1'b0;
      nxt_st.idle  = 1'b0;
      nxt_st.clk_run = 1'b0;
      nxt_st.ovf_ok  = 1'b0;
      nxt_st.ts    = 1'b0;
      nxt_st.sy    = 1'b0;
      nxt_st.fovf  = 1'b0;
      nxt_st.iack  = 1'b0;
      nxt_st.frdy  = 1'b0;
    end
  end

  // Either filtered enable low means tracing not permitted
  assign perm_low = !st_ff.pin[0] || !st_ff.pin[1];

  // ************************************************************
  // State register
  // ************************************************************
  // Single clocked process, reset handled in the copy above
  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Every output is a field of the state register
  assign dbg_rdata           = st_ff.rdata;
  assign dbg_ack             = st_ff.ack;
  assign addr_match          = st_ff.match;
  assign trace_flush_req     = st_ff.flush;
  assign trace_idle_req      = st_ff.idle;
  assign core_if_clock_run   = st_ff.clk_run;
  assign core_if_overflow_ok = st_ff.ovf_ok;
  assign ts_insert           = st_ff.ts;
  assign sync_insert         = st_ff.sy;
  assign fifo_force_overflow = st_ff.fovf;
  assign idle_ack            = st_ff.iack;
  assign flush_ready         = st_ff.frdy;

endmodule // trace_comparator_aux_control
`default_nettype wire

// ### test/trace_cmp_monitor.sv
// Port-level assertions for the trace comparator block
`timescale 1ns/1ps
`default_nettype none
module trace_cmp_monitor #(
  parameter int NUM_CMP = 8
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        dbg_sel,
  input wire logic        dbg_write,
  input wire logic [11:0] dbg_addr,
  input wire logic [31:0] dbg_rdata,
  input wire logic        dbg_ack,
  input wire logic        cmp_valid,
  input wire logic [7:0]  addr_match,
  input wire logic        trace_idle,
  input wire logic        fifo_drained,
  input wire logic        idle_ack,
  input wire logic        flush_ready,
  input wire logic        ts_request,
  input wire logic        trace_activity_low,
  input wire logic        ts_insert
);
  // ************************************************************
  // Checks, all on the core clock
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_ack_follows_sel: assert property (dbg_sel |=> dbg_ack)
    else $error("access not acknowledged");
  a_rdata_idle_zero: assert property (!dbg_ack |-> dbg_rdata == 32'h0)
    else $error("read data outside an answer");
  a_status_fixed: assert property (
    dbg_sel && !dbg_write && dbg_addr == 12'hfb8
    |=> (dbg_rdata & 32'hffffff33) == 32'h0 && dbg_rdata[7] && dbg_rdata[3])
    else $error("status fields wrong");
  a_qual_reserved: assert property (
    dbg_sel && !dbg_write && dbg_addr >= 12'h480 && dbg_addr <= 12'h4bc
    |=> (dbg_rdata & ~32'h00007b0c) == 32'h0)
    else $error("qualifier reserved bit set");
  a_match_no_valid: assert property (!cmp_valid |=> addr_match == 8'h00)
    else $error("match without sample");
  a_upper_quiet: assert property ((addr_match >> NUM_CMP) == 8'h00)
    else $error("match on absent comparator");
  a_idle_ack_up: assert property (trace_idle |=> idle_ack)
    else $error("idle acknowledge missing");
  a_flush_ready_up: assert property (trace_idle || fifo_drained |=> flush_ready)
    else $error("flush ready missing");
  a_ts_gated: assert property (!ts_request |=> !ts_insert)
    else $error("timestamp without request");
  a_ts_quiet_go: assert property (ts_request && trace_activity_low |=> ts_insert)
    else $error("timestamp not inserted");
  // Main scenarios reached
  cover property (dbg_ack && dbg_rdata != 32'h0);
  cover property (addr_match[0]);
  cover property (ts_insert && !trace_activity_low);
endmodule // trace_cmp_monitor

bind trace_comparator_aux_control trace_cmp_monitor #(.NUM_CMP(NUM_CMP)) trace_cmp_monitor_i (
  .mclk(mclk), .rst(rst), .dbg_sel(dbg_sel), .dbg_write(dbg_write), .dbg_addr(dbg_addr),
  .dbg_rdata(dbg_rdata), .dbg_ack(dbg_ack), .cmp_valid(cmp_valid), .addr_match(addr_match),
  .trace_idle(trace_idle), .fifo_drained(fifo_drained), .idle_ack(idle_ack),
  .flush_ready(flush_ready), .ts_request(ts_request),
  .trace_activity_low(trace_activity_low), .ts_insert(ts_insert));
`default_nettype wire

// ### test/trace_comparator_aux_control_tb.sv
// Self-checking bench for the trace comparator block
`timescale 1ns/1ps
`default_nettype none
module trace_comparator_aux_control_tb;
  localparam logic [63:0] A = 64'h0123456789abcdef;  // Comparator address
  logic        mclk, rst, dbg_sel, dbg_write, dbg_ack;  // Clock, reset, port strobes
  logic [11:0] dbg_addr;                                 // Register address
  logic [31:0] dbg_wdata, dbg_rdata;                     // Register data
  logic        nid_en, inv_en, sec_noninv_dbg_status_en;                  // Enable pins
  logic        cmp_valid, cmp_secure, cid_m, vm_m;       // Sample qualifiers
  logic [1:0]  cmp_level;                                // Sample level
  logic [63:0] cmp_addr;                                 // Sample address
  logic [7:0]  addr_match;                               // Match vector
  logic        dse, t_idle, drained, act_low, ts_req, sy_req, sy_del;  // Unit status
  logic        fl_req, id_req, clk_run, ovf_ok, ts_ins, sy_ins, f_ovf, id_ack, fl_rdy;
  int          bad_count, comparisons;                   // Tallies
  // Free-running 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  trace_comparator_aux_control trace_comparator_aux_control_i (
    .mclk(mclk), .rst(rst), .dbg_sel(dbg_sel), .dbg_write(dbg_write), .dbg_addr(dbg_addr),
    .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata), .dbg_ack(dbg_ack),
    .noninvasive_debug_enable(nid_en), .invasive_debug_enable(inv_en),
    .secure_noninv_enable(sec_noninv_dbg_status_en), .cmp_valid(cmp_valid), .cmp_addr(cmp_addr),
    .cmp_secure(cmp_secure), .cmp_level(cmp_level), .ctxid_match(cid_m),
    .virtual_machine_identifier_match(vm_m), .addr_match(addr_match),
    .debug_state_entry(dse), .trace_idle(t_idle), .fifo_drained(drained),
    .trace_activity_low(act_low), .ts_request(ts_req), .sync_request(sy_req),
    .sync_delayed(sy_del), .trace_flush_req(fl_req), .trace_idle_req(id_req),
    .core_if_clock_run(clk_run), .core_if_overflow_ok(ovf_ok), .ts_insert(ts_ins),
    .sync_insert(sy_ins), .fifo_force_overflow(f_ovf), .idle_ack(id_ack), .flush_ready(fl_rdy));
  trace_dbg_host trace_dbg_host_i (
    .mclk(mclk), .dbg_ack(dbg_ack), .dbg_rdata(dbg_rdata), .dbg_sel(dbg_sel),
    .dbg_write(dbg_write), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value at %0t: register %h not %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value at %0t: outputs %h not %h", $time, got, exp);
      bad_count++;
    end
  endtask
  // Access with a bounded wait; a lost answer ends the run
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    logic ok;
    trace_dbg_host_i.access(wr, a, d, r, ok);
    if (!ok) begin
      $display("wrong value at %0t: no answer", $time);
      bad_count++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    acc(1'b0, a, 32'h0, r);
    chk_reg(r, e);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    rd(12'h018, 32'h0);  // reset value zero
    wr(12'h018, 32'hffffffff);
    rd(12'h018, 32'h000001ff);  // upper bits dropped
    wr(12'h4b8, 32'hffffffff);
    rd(12'h4b8, 32'h00007b0c);  // last qualifier masked
    rd(12'h4bc, 32'h0);  // high word empty
    rd(12'h100, 32'h0);  // unmapped reads zero
    wr(12'h4b8, 32'h0);
    wr(12'h018, 32'h0);
    $display("test registers done");
  endtask
  // Same qualifier on comparators 0 and 7, one sample
  task automatic row(input logic [15:0] q, input logic s, input logic [1:0] l,
                     input logic c, input logic v, input logic [63:0] a, input logic e);
    wr(12'h480, {16'h0, q});
    wr(12'h4b8, {16'h0, q});
    {cmp_valid, cmp_secure, cmp_level, cid_m, vm_m, cmp_addr} = {1'b1, s, l, c, v, a};
    @(negedge mclk);
    {cmp_valid, cmp_addr} = {1'b0, ~a};
    chk_bits(addr_match, e ? 8'h81 : 8'h00);
  endtask
  task automatic t_match();
    wr(12'h400, A[31:0]);
    wr(12'h404, A[63:32]);
    wr(12'h438, A[31:0]);
    wr(12'h43c, A[63:32]);
    row(16'h0000, 1'b0, 2'h0, 1'b0, 1'b0, A, 1'b1);  // address alone
    row(16'h0000, 1'b0, 2'h0, 1'b0, 1'b0, A ^ 64'h8000000000000000, 1'b0);  // top bit
    row(16'h1000, 1'b0, 2'h0, 1'b0, 1'b0, A, 1'b0);  // level 0 off
    row(16'h1000, 1'b0, 2'h1, 1'b0, 1'b0, A, 1'b1);  // level 1 on
    row(16'h2000, 1'b0, 2'h1, 1'b0, 1'b0, A, 1'b0);  // level 1 off
    row(16'h4000, 1'b0, 2'h2, 1'b0, 1'b0, A, 1'b0);  // level 2 off
    row(16'hb000, 1'b0, 2'h2, 1'b0, 1'b0, A, 1'b1);  // level 2 on
    row(16'h0000, 1'b0, 2'h3, 1'b0, 1'b0, A, 1'b0);  // no level 3 gate
    row(16'h0100, 1'b1, 2'h0, 1'b0, 1'b0, A, 1'b0);  // level 0 off
    row(16'h0200, 1'b1, 2'h1, 1'b0, 1'b0, A, 1'b0);  // level 1 off
    row(16'h0800, 1'b1, 2'h3, 1'b0, 1'b0, A, 1'b0);  // level 3 off
    row(16'h0700, 1'b1, 2'h3, 1'b0, 1'b0, A, 1'b1);  // level 3 on
    row(16'h0000, 1'b1, 2'h2, 1'b0, 1'b0, A, 1'b0);  // no level 2 gate
    row(16'h0004, 1'b0, 2'h0, 1'b0, 1'b1, A, 1'b0);  // context missing
    row(16'h0004, 1'b0, 2'h0, 1'b1, 1'b0, A, 1'b1);  // context present
    row(16'h0008, 1'b0, 2'h0, 1'b1, 1'b0, A, 1'b0);  // machine id missing
    row(16'h0008, 1'b0, 2'h0, 1'b0, 1'b1, A, 1'b1);  // machine id present
    row(16'h000c, 1'b0, 2'h0, 1'b1, 1'b0, A, 1'b0);  // one of two
    row(16'h000c, 1'b0, 2'h0, 1'b1, 1'b1, A, 1'b1);  // both present
    $display("test compare done");
  endtask
  // Pins pass a three-stage filter first
  task automatic pins(input logic n, input logic i, input logic s, input logic [31:0] e);
    {nid_en, inv_en, sec_noninv_dbg_status_en} = {n, i, s};
    repeat (6) @(negedge mclk);
    rd(12'hfb8, e);
  endtask
  task automatic t_stat();
    pins(1'b0, 1'b0, 1'b0, 32'h00000088);  // all disabled
    pins(1'b1, 1'b1, 1'b0, 32'h0000008c);  // non-secure enabled
    pins(1'b0, 1'b1, 1'b1, 32'h00000088);  // needs both pins
    pins(1'b1, 1'b1, 1'b1, 32'h000000cc);  // secure enabled
    $display("test status done");
  endtask
  task automatic t_ctrl();
    logic [7:0] n;
    {ts_req, sy_req, sy_del, act_low, t_idle, drained} = 6'h38;
    for (int i = 0; i < 5; i++) begin
      wr(12'h018, 32'h1 << i);
      @(negedge mclk);
      chk_bits({3'h0, ts_ins, sy_ins, f_ovf, id_ack, fl_rdy}, 8'h1 << i);
    end
    wr(12'h018, 32'h0);
    {act_low, drained} = 2'h3;
    @(negedge mclk);
    chk_bits({3'h0, ts_ins, sy_ins, f_ovf, id_ack, fl_rdy}, 8'h19);
    wr(12'h018, 32'hc0);
    @(negedge mclk);
    chk_bits({6'h0, clk_run, ovf_ok}, 8'h03);  // both set
    wr(12'h018, 32'h40);
    @(negedge mclk);
    chk_bits({6'h0, clk_run, ovf_ok}, 8'h01);  // gate back on
    for (int i = 0; i < 2; i++) begin
      wr(12'h018, i ? 32'h100 : 32'h0);
      {dse, t_idle} = 2'h3;
      @(negedge mclk);
      dse = 1'b0;
      chk_bits({7'h0, fl_req}, i ? 8'h0 : 8'h1);  // entry flush
    end
    wr(12'h018, 32'h0);
    nid_en = 1'b0;
    n = 8'h0;
    repeat (8) begin
      @(negedge mclk);
      n = n + {7'h0, fl_req};
    end
    chk_bits({n[3:0], 3'h0, id_req}, 8'h11);  // one flush, idle held
    wr(12'h018, 32'h20);
    @(negedge mclk);
    chk_bits({7'h0, id_req}, 8'h0);  // override keeps running
    nid_en = 1'b1;
    $display("test controls done");
  endtask
  // Main sequence
  initial begin
    bad_count = 0;
    comparisons = 0;
    rst = 1'b1;
    {nid_en, inv_en, sec_noninv_dbg_status_en, cmp_valid, cmp_secure, cid_m, vm_m, cmp_level, cmp_addr} = '0;
    {dse, t_idle, drained, act_low, ts_req, sy_req, sy_del} = '0;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    t_regs();
    t_match();
    t_stat();
    t_ctrl();
    finish_test();
  end
endmodule // trace_comparator_aux_control_tb
`default_nettype wire

// ### test/trace_dbg_host.sv
// Debug host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module trace_dbg_host (
  input  wire logic        mclk,
  input  wire logic        dbg_ack,
  input  wire logic [31:0] dbg_rdata,
  output var  logic        dbg_sel,
  output var  logic        dbg_write,
  output var  logic [11:0] dbg_addr,
  output var  logic [31:0] dbg_wdata
);
  // Idle port at time zero
  initial begin
    {dbg_sel, dbg_write, dbg_addr, dbg_wdata} = '0;
  end
  // One access
  // Select is one cycle wide, since every selected cycle is an access
  task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic ok);
    ok = 1'b0;
    rd = 32'h0;
    @(negedge mclk);
    {dbg_sel, dbg_write, dbg_addr, dbg_wdata} = {1'b1, wr, a, d};
    @(negedge mclk);
    // Released lines show the inverse, never the stale value
    {dbg_sel, dbg_write, dbg_addr, dbg_wdata} = {1'b0, ~wr, ~a, ~d};
    for (int n = 0; n < 3 && !ok; n++) begin
      if (dbg_ack === 1'b1) {rd, ok} = {dbg_rdata, 1'b1};
      else @(negedge mclk);
    end
  endtask
endmodule // trace_dbg_host
`default_nettype wire
